// ===== biow_cfg_regs.sv
// Configuration registers 0x30, 0x34 and 0x3C of a bridge type-1 header.
// Assumes one config access per cycle from the PCI target logic, synchronous to core_clk.
`timescale 1ns/10ps
`include "biow_map.svh"
module biow_cfg_regs import biow_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Configuration access, dword address and active-high byte enables
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  // Read answer, one cycle after the request
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Window limits for the forwarding decode
  output logic [31:0] io_window_bottom,
  output logic [31:0] io_window_top,
  // Interrupt request, never asserted
  output logic irq_out
);
  // ****************************************
  // Decode
  // ****************************************
  logic sel_io;
  logic sel_irq;
  logic [4:0] wen;
  biow_half_t io_bottom_high;
  biow_half_t io_top_high_bits;
  biow_byte_t irq_routing;
  biow_byte_t capability_offset;

  typedef struct packed {
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] bottom;
    logic [31:0] top;
    logic irq;
  } biow_top_s;
  biow_top_s st_q;
  biow_top_s st_d;

  assign capability_offset = `BIOW_CAPABILITY_OFFSET;

  always_comb begin
    sel_io = 1'b0;
    sel_irq = 1'b0;
    if (cfg_addr == `BIOW_OFF_IO_WINDOW) begin
      sel_io = cfg_wr;
    end else if (cfg_addr == `BIOW_OFF_IRQ) begin
      sel_irq = cfg_wr;
    end
    // Per-byte enables; capability dword and pin byte get none
    wen[0] = sel_io & cfg_be[0];
    wen[1] = sel_io & cfg_be[1];
    wen[2] = sel_io & cfg_be[2];
    wen[3] = sel_io & cfg_be[3];
    wen[4] = sel_irq & cfg_be[0];
  end

  // ****************************************
  // Storage bytes
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_io
      biow_byte_reg #(.RST_VAL(8'h00)) u_bot (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_en(wen[g]),
        .wr_data(cfg_wdata[8*g +: 8]),
        .value_q(io_bottom_high[8*g +: 8])
      );
      biow_byte_reg #(.RST_VAL(8'h00)) u_top (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_en(wen[g+2]),
        .wr_data(cfg_wdata[16+8*g +: 8]),
        .value_q(io_top_high_bits[8*g +: 8])
      );
    end
  endgenerate

  biow_byte_reg #(.RST_VAL(`BIOW_IRQ_ROUTING_RST)) u_irq_routing (
    .core_clk(core_clk),
    .resetn(resetn),
    .wr_en(wen[4]),
    .wr_data(cfg_wdata[7:0]),
    .value_q(irq_routing)
  );

  // ****************************************
  // Read mux and outputs
  // ****************************************
  // Registered answer so rdata never shows decode glitches
  always_comb begin
    st_d = st_q;
    st_d.rvalid = cfg_rd;
    st_d.rdata = 32'h0000_0000;
    if (cfg_rd) begin
      if (cfg_addr == `BIOW_OFF_IO_WINDOW) begin
        st_d.rdata = {io_top_high_bits, io_bottom_high};
      end else if (cfg_addr == `BIOW_OFF_CAP_PTR) begin
        st_d.rdata = {24'h000000, capability_offset};
      end else if (cfg_addr == `BIOW_OFF_IRQ) begin
        st_d.rdata = {16'h0000, `BIOW_IRQ_PIN_VALUE, irq_routing};
      end
    end
    // 64KB granularity: bottom low 16 bits zero, top low 16 bits ones
    st_d.bottom = {io_bottom_high, 16'h0000};
    st_d.top = {io_top_high_bits, 16'hFFFF};
    st_d.irq = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q.rdata <= 32'h0000_0000;
      st_q.rvalid <= 1'b0;
      st_q.bottom <= 32'h0000_0000;
      st_q.top <= 32'h0000_FFFF;
      st_q.irq <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_rdata = st_q.rdata;
  assign cfg_rvalid = st_q.rvalid;
  assign io_window_bottom = st_q.bottom;
  assign io_window_top = st_q.top;
  assign irq_out = st_q.irq;

  // ****************************************
  // Checks
  // ****************************************
  property p_irq_never;
    @(posedge core_clk) disable iff (!resetn) !irq_out;
  endproperty
  a_irq_never: assert property (p_irq_never) else $error("irq asserted");

  property p_cap_read;
    @(posedge core_clk) disable iff (!resetn)
      (cfg_rd && cfg_addr == `BIOW_OFF_CAP_PTR) |=> (cfg_rvalid && cfg_rdata == 32'h0000_00DC);
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability read wrong");

  property p_cap_high_zero;
    @(posedge core_clk) disable iff (!resetn)
      (cfg_rd && cfg_addr == `BIOW_OFF_CAP_PTR) |=> cfg_rdata[31:8] == 24'h000000;
  endproperty
  a_cap_high_zero: assert property (p_cap_high_zero) else $error("capability high bits set");

  property p_pin_zero;
    @(posedge core_clk) disable iff (!resetn)
      (cfg_rd && cfg_addr == `BIOW_OFF_IRQ) |=> cfg_rdata[15:8] == 8'h00;
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("pin byte nonzero");

  property p_bottom_write;
    @(posedge core_clk) disable iff (!resetn)
      (cfg_wr && cfg_addr == `BIOW_OFF_IO_WINDOW && cfg_be[1:0] == 2'b11) ##1 !cfg_wr
        |=> io_window_bottom[31:16] == $past(cfg_wdata[15:0], 2);
  endproperty
  a_bottom_write: assert property (p_bottom_write) else $error("bottom not written");

  property p_top_write;
    @(posedge core_clk) disable iff (!resetn)
      (cfg_wr && cfg_addr == `BIOW_OFF_IO_WINDOW && cfg_be[3:2] == 2'b11) ##1 !cfg_wr
        |=> io_window_top[31:16] == $past(cfg_wdata[31:16], 2);
  endproperty
  a_top_write: assert property (p_top_write) else $error("top not written");

  property p_gran;
    @(posedge core_clk) disable iff (!resetn)
      io_window_bottom[11:0] == 12'h000 && io_window_top[11:0] == 12'hFFF;
  endproperty
  a_gran: assert property (p_gran) else $error("window not 4KB granular");

  property p_be_mask;
    @(posedge core_clk) disable iff (!resetn)
      (!cfg_wr ##1 (cfg_wr && cfg_addr == `BIOW_OFF_IO_WINDOW && cfg_be[3:2] == 2'b00))
        |=> ##1 $stable(io_window_top);
  endproperty
  a_be_mask: assert property (p_be_mask) else $error("disabled bytes changed");

  property p_rvalid_pulse;
    @(posedge core_clk) disable iff (!resetn)
      !cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer without request");

  property p_routing_wr_mask;
    @(posedge core_clk) disable iff (!resetn)
      (cfg_wr && cfg_addr == `BIOW_OFF_IRQ && !cfg_be[0]) |=> $stable(irq_routing);
  endproperty
  a_routing_wr_mask: assert property (p_routing_wr_mask) else $error("masked routing byte changed");

  // Routing byte comes back as 0xFF after every reset
  property p_routing_reset;
    @(posedge core_clk) !resetn |=> irq_routing == `BIOW_IRQ_ROUTING_RST;
  endproperty
  a_routing_reset: assert property (p_routing_reset) else $error("routing reset value wrong");

  // Main traffic kinds seen at least once
  c_window_write: cover property (@(posedge core_clk) cfg_wr && cfg_addr == `BIOW_OFF_IO_WINDOW);
  c_cap_read: cover property (@(posedge core_clk) cfg_rd && cfg_addr == `BIOW_OFF_CAP_PTR);
  c_irq_write: cover property (@(posedge core_clk) cfg_wr && cfg_addr == `BIOW_OFF_IRQ && cfg_be[0]);
  c_lane_skip: cover property (@(posedge core_clk) cfg_wr && cfg_addr == `BIOW_OFF_IO_WINDOW && cfg_be[3:2] == 2'b00);
endmodule // biow_cfg_regs

// ===== biow_map.svh
// Register offsets, reset values and constants of the I/O window slice.
// Included by the register bank, the host model and the bench; definitions only.
`ifndef BIOW_MAP_SVH
`define BIOW_MAP_SVH

`define BIOW_OFF_IO_WINDOW 8'h30
`define BIOW_OFF_CAP_PTR 8'h34
`define BIOW_OFF_IRQ 8'h3C
`define BIOW_CAPABILITY_OFFSET 8'hDC
`define BIOW_IRQ_ROUTING_RST 8'hFF
`define BIOW_IRQ_PIN_VALUE 8'h00
`define BIOW_IO_HIGH_RST 16'h0000
`define BIOW_IO_GRAN_BITS 12

`endif

// ===== biow_pkg.sv
// Types of the I/O window configuration slice.
// Used by the register bank and its byte lane helper.
package biow_pkg;
  typedef logic [15:0] biow_half_t;
  typedef logic [7:0] biow_byte_t;
endpackage

// ===== biow_byte_reg.sv
// One writable configuration byte with its own enable and reset value.
// Assumes a synchronous active-low reset on core_clk.
`timescale 1ns/10ps
module biow_byte_reg import biow_pkg::*; #(
  parameter biow_byte_t RST_VAL = 8'h00
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Write port
  input wire logic wr_en,
  input wire biow_byte_t wr_data,
  // Stored value
  output biow_byte_t value_q
);
  typedef struct packed {
    biow_byte_t val;
  } biow_byte_s;
  biow_byte_s st_q;
  biow_byte_s st_d;

  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.val = wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q.val <= RST_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign value_q = st_q.val;
endmodule // biow_byte_reg

// ===== biow_host_model.sv
// Host configuration software model issuing config cycles.
// Assumes reads are answered one cycle after the request edge.
`timescale 1ns/10ps
`include "biow_map.svh"
module biow_host_model (
  // Clock
  input wire logic core_clk,
  // Requests
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  // Answer
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  initial begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // Data goes to its inverse once released, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge core_clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, b, d};
    @(posedge core_clk);
    {cfg_wr, cfg_be, cfg_wdata} <= {1'b0, 4'h0, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge core_clk);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata;
    v = cfg_rvalid;
  endtask
  // Bring-up sequence before the window is relied on
  task automatic init(input logic [31:0] win);
    wr(`BIOW_OFF_IO_WINDOW, 4'hF, win);
    wr(`BIOW_OFF_IRQ, 4'h1, 32'h000000FF);
  endtask
endmodule // biow_host_model

// ===== biow_cfg_regs_tb.sv
// Self-checking bench of the I/O window config slice.
// Assumes the host model drives every request.
`timescale 1ns/10ps
`include "biow_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module biow_cfg_regs_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_wr, cfg_rd, cfg_rvalid, irq_out;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, io_window_bottom, io_window_top;
  int mismatches = 0;
  int n_tests = 0;
  always #5 core_clk = ~core_clk;
  biow_cfg_regs biow_cfg_regs_inst (.core_clk(core_clk), .resetn(resetn), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .io_window_bottom(io_window_bottom),
    .io_window_top(io_window_top), .irq_out(irq_out));
  biow_host_model biow_host_model_inst (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid));
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic v;
    biow_host_model_inst.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask
  task automatic wchk(input logic [31:0] bot, input logic [31:0] top);
    `CHK(io_window_bottom, bot)
    `CHK(io_window_top, top)
    `CHK(irq_out, 1'b0)
  endtask
  task automatic t_reset_values;
    rchk(`BIOW_OFF_IO_WINDOW, 32'h00000000);
    rchk(`BIOW_OFF_CAP_PTR, 32'h000000DC);
    rchk(`BIOW_OFF_IRQ, 32'h000000FF);
    wchk(32'h00000000, 32'h0000FFFF);
    $display("test reset_values done");
  endtask
  // Split byte lanes prove each enable acts alone
  task automatic t_byte_lanes;
    biow_host_model_inst.wr(`BIOW_OFF_IO_WINDOW, 4'h5, 32'h1234ABCD);
    rchk(`BIOW_OFF_IO_WINDOW, 32'h003400CD);
    biow_host_model_inst.wr(`BIOW_OFF_IO_WINDOW, 4'hA, 32'h5678EF01);
    rchk(`BIOW_OFF_IO_WINDOW, 32'h5634EFCD);
    wchk(32'hEFCD0000, 32'h5634FFFF);
    $display("test byte_lanes done");
  endtask
  task automatic t_read_only;
    biow_host_model_inst.wr(`BIOW_OFF_CAP_PTR, 4'hF, 32'hFFFFFFFF);
    rchk(`BIOW_OFF_CAP_PTR, 32'h000000DC);
    biow_host_model_inst.wr(`BIOW_OFF_IRQ, 4'hF, 32'hA5A5A5A5);
    rchk(`BIOW_OFF_IRQ, 32'h000000A5);
    rchk(8'h38, 32'h00000000);
    wchk(32'hEFCD0000, 32'h5634FFFF);
    $display("test read_only done");
  endtask
  task automatic t_host_init;
    biow_host_model_inst.init(32'hFFFF0000);
    rchk(`BIOW_OFF_IO_WINDOW, 32'hFFFF0000);
    rchk(`BIOW_OFF_IRQ, 32'h000000FF);
    wchk(32'h00000000, 32'hFFFFFFFF);
    $display("test host_init done");
  endtask
  // Masked lanes must leave the neighbouring field untouched
  task automatic t_lane_mask;
    biow_host_model_inst.wr(`BIOW_OFF_IO_WINDOW, 4'h3, 32'h98764321);
    rchk(`BIOW_OFF_IO_WINDOW, 32'hFFFF4321);
    biow_host_model_inst.wr(`BIOW_OFF_IRQ, 4'hE, 32'h00000000);
    rchk(`BIOW_OFF_IRQ, 32'h000000FF);
    wchk(32'h43210000, 32'hFFFFFFFF);
    $display("test lane_mask done");
  endtask
  // Reset in mid-run must restore the power-up values
  task automatic t_mid_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    rchk(`BIOW_OFF_IO_WINDOW, 32'h00000000);
    rchk(`BIOW_OFF_IRQ, 32'h000000FF);
    wchk(32'h00000000, 32'h0000FFFF);
    $display("test mid_reset done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Tests need well under 200 cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    mismatches++;
    results();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset_values();
    t_byte_lanes();
    t_read_only();
    t_host_init();
    t_lane_mask();
    t_mid_reset();
    results();
  end
endmodule // biow_cfg_regs_tb
